// ---- core/embi_pkg.sv ----
// embi_pkg: constants and types shared by the external memory bus interface.
// assumes one clock tick per oscillator period, so every timing figure is in clock ticks.
// Functional notes
// - strap high: code at 0000H through 1FFFH comes from internal program memory.
// - strap low: every instruction fetch goes to external program memory.
// - program store strobe once per six periods on external fetch, none in data access.
// - program store strobe stays high while code runs from internal memory.
// - address latch strobe pulses every six periods except during external data access.
// - latch strobe marks low byte capture, and page byte capture for 24-bit data.
// - low port carries the address first (page byte, then low byte, on data access), then the data byte.
// - in bus use the low port drives ones actively while it emits a byte, and floats while it reads.
// - as open-drain port, a pin written with one floats as an input.
// - upper port drives high address on fetch, middle and high bytes on data.
// - write strobe makes external memory capture the byte on the low port.
// - read strobe lets external data memory drive its byte onto the low port.
// - program store pin pulled low at reset selects serial download mode.
package embi_pkg;

	localparam int EMBI_PH_W = 4;
	localparam logic [3:0] EMBI_SLOT_LEN = 4'h6;
	localparam logic [3:0] EMBI_DATA_LEN = 4'hC;
	// latch strobe high for ticks 0..1 of every slot except the second slot of a data access
	localparam logic [3:0] EMBI_ALE_END = 4'h2;
	// data access: second latch pulse for ticks 3..4
	localparam logic [3:0] EMBI_ALE2_BEG = 4'h3;
	localparam logic [3:0] EMBI_ALE2_END = 4'h5;
	// program store strobe low from tick 3 to the end of the slot
	localparam logic [3:0] EMBI_PSTB_BEG = 4'h3;
	// read or write strobe low for ticks 6..10
	localparam logic [3:0] EMBI_DSTB_BEG = 4'h6;
	localparam logic [3:0] EMBI_DSTB_END = 4'hB;
	// pin input delay through the three-stage filter
	localparam int EMBI_SYNC_LAG = 4;
	localparam logic [2:0] EMBI_SYNC_LAG_C = 3'h4;
	localparam int EMBI_RESET_MIN_CYCLES = 24;
	localparam logic [15:0] EMBI_INT_CODE_TOP = 16'h1FFF;
	localparam logic [7:0] EMBI_BYTE_ALL = 8'hFF;
	localparam logic [7:0] EMBI_BYTE_NONE = 8'h00;

	typedef enum logic [2:0] {
		EMBI_IDLE,
		EMBI_CODE_INT,
		EMBI_CODE_EXT,
		EMBI_DATA_RD,
		EMBI_DATA_WR
	} embi_kind_e;

endpackage

// ---- core/embi_sync_if.sv ----
// embi_sync_if: raw pin levels in, filtered levels out.
// assumes both ends run on the same mclk.
`timescale 1ns/1ps
interface embi_sync_if #(
	parameter int W = 10
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// ---- core/embi_sync3.sv ----
// embi_sync3: three-stage pin filter; a change counts once stages two and three agree.
// assumes raw levels are asynchronous to mclk.
`timescale 1ns/1ps
module embi_sync3 #(
	parameter int W = 10
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	embi_sync_if.filt sio
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] clean_ff;

	// first stage feeds only the second one
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else if (ce_i) begin
			s1_ff <= sio.raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// per bit: take stage three only when it matches stage two
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			clean_ff <= '0;
		end else if (ce_i) begin
			clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
		end
	end

	assign sio.clean = clean_ff;
endmodule

// ---- core/embi_bus.sv ----
// embi_bus: multiplexed external program/data bus sequencer with strap and download sampling.
// assumes core requests are on mclk and held until acknowledged; pins are asynchronous.
`timescale 1ns/1ps
module embi_bus (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic fetch_req_i,
	input wire logic [15:0] fetch_addr_i,
	output logic fetch_ack_o,
	output logic fetch_internal_o,
	output logic [7:0] fetch_data_o,
	input wire logic xdata_req_i,
	input wire logic xdata_we_i,
	input wire logic [23:0] xdata_addr_i,
	input wire logic [7:0] xdata_wdata_i,
	output logic xdata_ack_o,
	output logic [7:0] xdata_rdata_o,
	input wire logic [7:0] gp_p0_i,
	input wire logic [7:0] gp_p2_i,
	output logic [7:0] gp_p0_o,
	input wire logic [7:0] low_addr_data_port_i,
	output logic [7:0] low_addr_data_port_o,
	output logic [7:0] low_addr_data_port_oe_o,
	output logic [7:0] upper_address_port_o,
	output logic [7:0] upper_address_port_oe_o,
	output logic addr_latch_strobe_o,
	input wire logic program_store_strobe_n_i,
	output logic program_store_strobe_n_o,
	output logic program_store_strobe_n_oe_o,
	output logic read_strobe_n_o,
	output logic write_strobe_n_o,
	input wire logic external_fetch_strap_i,
	output logic ext_strap_o,
	output logic download_mode_o,
	output logic running_o
);
	import embi_pkg::*;

	embi_sync_if #(.W(10)) sio ();
	logic [7:0] p0_clean;
	logic strap_clean;
	logic pstore_clean;

	// pins: low port, strap and program store pin share one filter
	assign sio.raw = {program_store_strobe_n_i, external_fetch_strap_i, low_addr_data_port_i};
	assign p0_clean = sio.clean[7:0];
	assign strap_clean = sio.clean[8];
	assign pstore_clean = sio.clean[9];

	embi_sync3 #(.W(10)) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sio(sio)
	);

	logic [2:0] boot_cnt_ff;
	logic run_ff;
	logic strap_ff;
	logic dl_ff;
	logic [EMBI_PH_W-1:0] ph_ff;
	embi_kind_e kind_ff;
	embi_kind_e nxt_kind;
	logic [EMBI_PH_W-1:0] last_ph;
	logic take;
	logic pend_ff;
	logic [23:0] addr_ff;
	logic [7:0] wdata_ff;
	logic [EMBI_SYNC_LAG-1:0] cap_pipe_ff;
	logic cap_code_ff;
	logic bus_use;

	// straps are caught after release, once the filter has settled
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			boot_cnt_ff <= 3'h0;
			run_ff <= 1'b0;
			strap_ff <= 1'b0;
			dl_ff <= 1'b0;
		end else if (ce_i && boot_cnt_ff != EMBI_SYNC_LAG_C + 3'h1) begin
			boot_cnt_ff <= boot_cnt_ff + 3'h1;
			// filter output first shows the pin after the fourth edge, so read it on the fifth
			if (boot_cnt_ff == EMBI_SYNC_LAG_C) begin
				strap_ff <= strap_clean;
				dl_ff <= ~pstore_clean;
				run_ff <= pstore_clean;
			end
		end
	end

	// slot length: data access spans two slots
	assign last_ph = (kind_ff == EMBI_DATA_RD || kind_ff == EMBI_DATA_WR) ?
		EMBI_DATA_LEN - 4'h1 : EMBI_SLOT_LEN - 4'h1;
	assign take = run_ff && ph_ff == last_ph && !pend_ff;

	// next slot kind: data access beats code fetch
	always_comb begin
		nxt_kind = EMBI_IDLE;
		if (take) begin
			if (xdata_req_i) begin
				nxt_kind = xdata_we_i ? EMBI_DATA_WR : EMBI_DATA_RD;
			end else if (fetch_req_i) begin
				if (strap_ff && fetch_addr_i <= EMBI_INT_CODE_TOP) begin
					nxt_kind = EMBI_CODE_INT;
				end else begin
					nxt_kind = EMBI_CODE_EXT;
				end
			end
		end
	end

	// slot sequencer
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ph_ff <= '0;
			kind_ff <= EMBI_IDLE;
		end else if (ce_i && run_ff) begin
			if (ph_ff == last_ph) begin
				ph_ff <= '0;
				kind_ff <= nxt_kind;
			end else begin
				ph_ff <= ph_ff + 4'h1;
			end
		end
	end

	// request capture; fetch address sits in the low 16 bits
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			addr_ff <= 24'h000000;
			wdata_ff <= 8'h00;
		end else if (ce_i && take) begin
			addr_ff <= xdata_req_i ? xdata_addr_i : {8'h00, fetch_addr_i};
			wdata_ff <= xdata_wdata_i;
		end
	end

	// read capture waits out the filter lag so it sees the pin at the slot's last tick
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cap_pipe_ff <= '0;
			cap_code_ff <= 1'b0;
		end else if (ce_i) begin
			cap_pipe_ff <= {cap_pipe_ff[EMBI_SYNC_LAG-2:0],
				run_ff && ph_ff == last_ph &&
				(kind_ff == EMBI_CODE_EXT || kind_ff == EMBI_DATA_RD)};
			if (run_ff && ph_ff == last_ph) begin
				cap_code_ff <= kind_ff == EMBI_CODE_EXT;
			end
		end
	end

	// answers to the core; one outstanding request at a time
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pend_ff <= 1'b0;
			fetch_ack_o <= 1'b0;
			fetch_internal_o <= 1'b0;
			fetch_data_o <= 8'h00;
			xdata_ack_o <= 1'b0;
			xdata_rdata_o <= 8'h00;
		end else if (ce_i) begin
			fetch_ack_o <= 1'b0;
			fetch_internal_o <= 1'b0;
			xdata_ack_o <= 1'b0;
			if (take && nxt_kind != EMBI_IDLE) begin
				pend_ff <= 1'b1;
			end
			if (cap_pipe_ff[EMBI_SYNC_LAG-1]) begin
				pend_ff <= 1'b0;
				if (cap_code_ff) begin
					fetch_ack_o <= 1'b1;
					fetch_data_o <= p0_clean;
				end else begin
					xdata_ack_o <= 1'b1;
					xdata_rdata_o <= p0_clean;
				end
			end
			// internal code: no bus cycle, core reads its own memory
			if (run_ff && ph_ff == 4'h0 && kind_ff == EMBI_CODE_INT && pend_ff) begin
				pend_ff <= 1'b0;
				fetch_ack_o <= 1'b1;
				fetch_internal_o <= 1'b1;
			end
			if (run_ff && ph_ff == last_ph && kind_ff == EMBI_DATA_WR) begin
				pend_ff <= 1'b0;
				xdata_ack_o <= 1'b1;
			end
		end
	end

	assign bus_use = kind_ff == EMBI_CODE_EXT || kind_ff == EMBI_DATA_RD ||
		kind_ff == EMBI_DATA_WR;

	// strobes decoded from the sequencer registers
	always_comb begin
		addr_latch_strobe_o = 1'b0;
		program_store_strobe_n_o = 1'b1;
		read_strobe_n_o = 1'b1;
		write_strobe_n_o = 1'b1;
		if (run_ff) begin
			if (kind_ff == EMBI_DATA_RD || kind_ff == EMBI_DATA_WR) begin
				// page byte then low byte, no pulse in the second slot
				addr_latch_strobe_o = ph_ff < EMBI_ALE_END ||
					(ph_ff >= EMBI_ALE2_BEG && ph_ff < EMBI_ALE2_END);
				if (ph_ff >= EMBI_DSTB_BEG && ph_ff < EMBI_DSTB_END) begin
					read_strobe_n_o = kind_ff != EMBI_DATA_RD;
					write_strobe_n_o = kind_ff != EMBI_DATA_WR;
				end
			end else begin
				addr_latch_strobe_o = ph_ff < EMBI_ALE_END;
				// internal code and idle slots leave it high
				program_store_strobe_n_o = !(kind_ff == EMBI_CODE_EXT &&
					ph_ff >= EMBI_PSTB_BEG);
			end
		end
	end
	// released until straps are read with the pin high, so the download pull-down is visible
	assign program_store_strobe_n_oe_o = run_ff;

	// low port: address, then data; open drain when not on the bus
	always_comb begin
		low_addr_data_port_o = EMBI_BYTE_NONE;
		low_addr_data_port_oe_o = ~gp_p0_i;
		if (bus_use) begin
			low_addr_data_port_oe_o = EMBI_BYTE_NONE;
			if (kind_ff == EMBI_CODE_EXT) begin
				if (ph_ff < EMBI_PSTB_BEG) begin
					low_addr_data_port_o = addr_ff[7:0];
					low_addr_data_port_oe_o = EMBI_BYTE_ALL;
				end
			end else if (ph_ff < EMBI_ALE2_BEG) begin
				low_addr_data_port_o = addr_ff[23:16];
				low_addr_data_port_oe_o = EMBI_BYTE_ALL;
			end else if (ph_ff < EMBI_DSTB_BEG) begin
				low_addr_data_port_o = addr_ff[7:0];
				low_addr_data_port_oe_o = EMBI_BYTE_ALL;
			end else if (kind_ff == EMBI_DATA_WR) begin
				low_addr_data_port_o = wdata_ff;
				low_addr_data_port_oe_o = EMBI_BYTE_ALL;
			end
		end
	end

	// upper port: high byte on fetch, high then middle byte on data
	always_comb begin
		upper_address_port_o = gp_p2_i;
		upper_address_port_oe_o = EMBI_BYTE_ALL;
		if (kind_ff == EMBI_CODE_EXT) begin
			upper_address_port_o = addr_ff[15:8];
		end else if (kind_ff == EMBI_DATA_RD || kind_ff == EMBI_DATA_WR) begin
			upper_address_port_o = ph_ff < EMBI_ALE2_BEG ? addr_ff[23:16] : addr_ff[15:8];
		end
	end

	assign gp_p0_o = p0_clean;
	assign ext_strap_o = strap_ff;
	assign download_mode_o = dl_ff;
	assign running_o = run_ff;

	// checks, sampled only on enabled ticks
	default clocking cb @(posedge mclk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	sequence s_addr_phase;
		addr_latch_strobe_o[*2] ##1 (!addr_latch_strobe_o && low_addr_data_port_oe_o == 8'hFF);
	endsequence
	sequence s_fetch_strobe;
		program_store_strobe_n_o[*3] ##1 !program_store_strobe_n_o[*3];
	endsequence

	AST_EXT_FETCH_SLOT: assert property (
		run_ff && ph_ff == 4'h0 && kind_ff == EMBI_CODE_EXT |-> s_addr_phase and s_fetch_strobe)
		else $error("external fetch slot shape wrong");
	AST_INT_NO_PSTB: assert property (
		kind_ff != EMBI_CODE_EXT |-> program_store_strobe_n_o)
		else $error("program store strobe low outside external fetch");
	AST_ALE_PERIOD: assert property (
		run_ff && ph_ff == 4'h0 |-> addr_latch_strobe_o ##2 !addr_latch_strobe_o)
		else $error("latch strobe missing at slot start");
	AST_NO_ALE_DATA: assert property (
		(kind_ff == EMBI_DATA_RD || kind_ff == EMBI_DATA_WR) && ph_ff >= 4'h5 |->
		!addr_latch_strobe_o && program_store_strobe_n_o)
		else $error("strobe active in data slot");
	// only bus slots carry an address; idle slots pulse the latch over the open-drain port
	AST_ADDR_HOLD: assert property (
		$fell(addr_latch_strobe_o) && bus_use |->
		$stable(low_addr_data_port_o) && low_addr_data_port_oe_o == 8'hFF)
		else $error("address left port before latch fell");
	AST_WR_DATA: assert property (
		!write_strobe_n_o |->
		low_addr_data_port_oe_o == 8'hFF && low_addr_data_port_o == wdata_ff)
		else $error("write data not driven");
	AST_RD_RELEASE: assert property (
		$fell(read_strobe_n_o) |-> (low_addr_data_port_oe_o == 8'h00) [*5] ##1 read_strobe_n_o)
		else $error("read strobe or port release wrong");
	AST_P2_FETCH: assert property (
		kind_ff == EMBI_CODE_EXT |-> upper_address_port_o == addr_ff[15:8])
		else $error("upper port lacks fetch address");
	AST_GP_FLOAT: assert property (
		!bus_use |-> low_addr_data_port_oe_o == ~gp_p0_i && low_addr_data_port_o == 8'h00)
		else $error("open drain port misdriven");
	AST_STRAP_LOW: assert property (
		take && !xdata_req_i && fetch_req_i && !strap_ff |=> kind_ff == EMBI_CODE_EXT)
		else $error("fetch not external with strap low");
	AST_STRAP_HIGH: assert property (
		take && !xdata_req_i && fetch_req_i && strap_ff && fetch_addr_i <= EMBI_INT_CODE_TOP |=>
		kind_ff == EMBI_CODE_INT ##1 fetch_internal_o)
		else $error("internal fetch not served internally");
	AST_DL_QUIET: assert property (
		dl_ff |-> !run_ff && !program_store_strobe_n_oe_o && read_strobe_n_o && write_strobe_n_o)
		else $error("bus active in download mode");
endmodule

// ---- test/embi_ext_mem.sv ----
// embi_ext_mem: external code and data memory behind an address latch on the multiplexed bus.
// assumes strobes and port levels come from the bus block pins on the same mclk.
`timescale 1ns/1ps
module embi_ext_mem (
	input wire logic mclk_i,
	input wire logic ale_i,
	input wire logic pstore_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [7:0] lad_i,
	input wire logic [7:0] upper_i,
	output logic drv_en_o,
	output logic [7:0] drv_o,
	output logic [23:0] addr_o
);
	logic [7:0] mem [256];
	logic [7:0] low_ff, page_ff, drv_ff;
	logic ale_ff = 1'b0, hold_ff = 1'b0, wr_ff = 1'b1;
	logic strb;
	logic [7:0] code;

	// data space starts with a known pattern so unwritten reads are predictable
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'hC3;
		end
	end

	// latch is transparent while the strobe is high; a new pulse pushes the old byte to page
	always @(posedge mclk_i) begin
		ale_ff <= ale_i;
		if (ale_i && !ale_ff) begin
			page_ff <= low_ff;
		end
		if (ale_i) begin
			low_ff <= lad_i;
		end
	end

	// write lands as the strobe rises, data still on the port
	always @(posedge mclk_i) begin
		wr_ff <= wr_n_i;
		if (wr_n_i && !wr_ff) begin
			mem[low_ff] <= lad_i;
		end
	end

	assign strb = !pstore_n_i || !rd_n_i;
	assign code = low_ff ^ upper_i ^ 8'h5A;

	// one tick of hold after the strobe; the bus block samples late
	always @(posedge mclk_i) begin
		hold_ff <= strb;
		if (strb) begin
			drv_ff <= drv_o;
		end
		if (strb || !wr_n_i) begin
			addr_o <= {page_ff, upper_i, low_ff};
		end
	end

	assign drv_en_o = strb || hold_ff;
	assign drv_o = !pstore_n_i ? code : (!rd_n_i ? mem[low_ff] : drv_ff);
endmodule

// ---- test/external_memory_bus_interface_tb_top.sv ----
// testbench for the external memory bus block: table of bus operations, then strap cases.
// assumes embi_bus and the memory model above; one clock, synchronous reset.
`timescale 1ns/1ps
module external_memory_bus_interface_tb_top;
	import embi_pkg::*;
	typedef struct packed {
		logic [1:0] kind; // 0 fetch, 1 write, 2 read
		logic [23:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} embi_row_s;
	logic mclk_i = 1'b0, rst_i = 1'b1, freq = 1'b0, xreq = 1'b0, xwe = 1'b0;
	logic strap = 1'b0, pull = 1'b1;
	logic [15:0] faddr = 16'h0;
	logic [23:0] xaddr = 24'h0, maddr;
	logic [7:0] wdata = 8'h0, gp_low = 8'hF0, idle = 8'h55;
	logic [7:0] lad_o, lad_oe, up_o, mem_d, lad_pin, fdata, rdata, gp_in, up_oe;
	logic fack, fint, xack, ale, ps_o, ps_oe, ps_pin, rd_n, wr_n, mem_en, strap_q, dl, run;
	logic ale_q = 1'b0, ps_q = 1'b1, rd_q = 1'b1, wr_q = 1'b1;
	int bad_count = 0, n_checks = 0, n_ale = 0, n_ps = 0, n_rd = 0, n_wr = 0;
	embi_row_s rows [8] = '{
		'{2'd0, 24'h000000, 8'h00, 8'h5A},
		'{2'd0, 24'h001FFF, 8'h00, 8'hBA},
		'{2'd0, 24'h0012FF, 8'h00, 8'hB7},
		'{2'd1, 24'hA53C77, 8'h81, 8'h00},
		'{2'd2, 24'hA53C77, 8'h00, 8'h81},
		'{2'd2, 24'h0102FF, 8'h00, 8'h3C},
		'{2'd1, 24'h000010, 8'h00, 8'h00},
		'{2'd2, 24'h000010, 8'h00, 8'h00}
	};

	always #4 mclk_i = ~mclk_i;

	// a released port never holds its last value; pin store strobe has a pull resistor
	assign lad_pin = (lad_oe & lad_o) | (~lad_oe & (mem_en ? mem_d : idle));
	assign ps_pin = ps_oe ? ps_o : pull;

	// strobe edge counters
	always @(posedge mclk_i) begin
		idle <= ~idle;
		ale_q <= ale;
		ps_q <= ps_pin;
		rd_q <= rd_n;
		wr_q <= wr_n;
		n_ale += (ale && !ale_q);
		n_ps += (!ps_pin && ps_q);
		n_rd += (!rd_n && rd_q);
		n_wr += (!wr_n && wr_q);
	end

	embi_bus i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
		.fetch_req_i(freq), .fetch_addr_i(faddr), .fetch_ack_o(fack),
		.fetch_internal_o(fint), .fetch_data_o(fdata), .xdata_req_i(xreq),
		.xdata_we_i(xwe), .xdata_addr_i(xaddr), .xdata_wdata_i(wdata),
		.xdata_ack_o(xack), .xdata_rdata_o(rdata), .gp_p0_i(gp_low), .gp_p2_i(8'h3C),
		.gp_p0_o(gp_in), .low_addr_data_port_i(lad_pin), .low_addr_data_port_o(lad_o),
		.low_addr_data_port_oe_o(lad_oe), .upper_address_port_o(up_o),
		.upper_address_port_oe_o(up_oe), .addr_latch_strobe_o(ale),
		.program_store_strobe_n_i(ps_pin), .program_store_strobe_n_o(ps_o),
		.program_store_strobe_n_oe_o(ps_oe), .read_strobe_n_o(rd_n),
		.write_strobe_n_o(wr_n), .external_fetch_strap_i(strap), .ext_strap_o(strap_q),
		.download_mode_o(dl), .running_o(run));

	embi_ext_mem i_mem (.mclk_i(mclk_i), .ale_i(ale), .pstore_n_i(ps_pin), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .lad_i(lad_pin), .upper_i(up_o), .drv_en_o(mem_en), .drv_o(mem_d),
		.addr_o(maddr));

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done();
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// straps are captured once after release, so each strap case needs its own reset
	task automatic do_reset(input logic s, input logic p);
		@(posedge mclk_i);
		#1;
		rst_i = 1'b1;
		strap = s;
		pull = p;
		gp_low = 8'hF0;
		repeat (EMBI_RESET_MIN_CYCLES) @(posedge mclk_i);
		#1;
		chk("gp_oe", {16'h0, ~gp_low}, {16'h0, lad_oe});
		rst_i = 1'b0;
		gp_low = 8'hFF;
		repeat (12) @(posedge mclk_i);
		#1;
		chk("strap", {23'h0, s}, {23'h0, strap_q});
		chk("download", {23'h0, ~p}, {23'h0, dl});
		chk("running", {23'h0, p}, {23'h0, run});
		// no bus slot yet: upper port shows its general-purpose value, driven
		chk("upper", {16'h0, 8'h3C}, {16'h0, up_o});
		chk("upper_oe", {16'h0, 8'hFF}, {16'h0, up_oe});
	endtask

	// request held until acknowledged, dropped in the ack cycle so it is not taken twice
	task automatic do_op(input embi_row_s r, input logic intl);
		int n;
		n = 0;
		n_ps = 0;
		n_rd = 0;
		n_wr = 0;
		faddr = r.addr[15:0];
		xaddr = r.addr;
		wdata = r.wdata;
		xwe = (r.kind == 2'd1);
		freq = (r.kind == 2'd0);
		xreq = (r.kind != 2'd0);
		while (!(fack || xack) && n < 80) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		freq = 1'b0;
		xreq = 1'b0;
		chk("ack", 24'h1, {23'h0, fack | xack});
		if (r.kind == 2'd0) begin
			chk("internal", {23'h0, intl}, {23'h0, fint});
		end
		if (r.kind == 2'd0 && !intl) begin
			chk("code", {16'h0, r.exp}, {16'h0, fdata});
			chk("code_addr", {8'h0, r.addr[15:0]}, {8'h0, maddr[15:0]});
			// released port keeps the last byte that stood two samples running
			chk("gp_p0", {16'h0, r.exp}, {16'h0, gp_in});
		end
		if (r.kind != 2'd0) begin
			chk("data_addr", r.addr, maddr);
		end
		if (r.kind == 2'd2) begin
			chk("rdata", {16'h0, r.exp}, {16'h0, rdata});
			chk("gp_p0", {16'h0, r.exp}, {16'h0, gp_in});
		end
		chk("pstore_cnt", 24'((r.kind == 2'd0 && !intl) ? 1 : 0), 24'(n_ps));
		chk("rd_cnt", 24'(r.kind == 2'd2), 24'(n_rd));
		chk("wr_cnt", 24'(r.kind == 2'd1), 24'(n_wr));
		@(posedge mclk_i);
		#1;
	endtask

	initial begin
		do_reset(1'b0, 1'b1);
		foreach (rows[i]) begin
			do_op(rows[i], 1'b0);
		end
		// strap high: idle bus shows latch pulses only, low code stays inside
		do_reset(1'b1, 1'b1);
		n_ale = 0;
		n_ps = 0;
		repeat (60) @(posedge mclk_i);
		#1;
		chk("ale_pulses", 24'd10, 24'(n_ale));
		chk("pstore_idle", 24'd0, 24'(n_ps));
		do_op('{2'd0, 24'h001FFF, 8'h00, 8'h00}, 1'b1);
		do_op('{2'd0, 24'h002000, 8'h00, 8'h7A}, 1'b0);
		do_reset(1'b1, 1'b0);
		test_done();
	end

	// a hang counts as a mismatch
	initial begin
		#(8 * 6000);
		bad_count++;
		test_done();
	end
endmodule
